// File: arpt_conv_stage.sv
/*
  arpt_conv_stage: behavioural power stage on the far side of the PWM pins.
  Assumes the bench commands faults and capture edges through its tasks.
*/
`timescale 1ns/1ps
module arpt_conv_stage (
  input  wire logic       ref_clk,
  input  wire logic [3:0] modulated_out,
  input  wire logic [3:0] modulated_oe_n,
  output logic            shutdown_in_n,
  output logic            capture_in
);
  logic       fault;
  logic [3:0] gate_on;

  initial begin
    fault      = 1'b0;
    capture_in = 1'b0;
  end

  // fault line has a pull-up, so a released line reads high
  assign shutdown_in_n = ~fault;
  // gates only conduct on phases the timer owns
  assign gate_on       = modulated_out & ~modulated_oe_n;

  task automatic set_fault(input logic f);
    @(posedge ref_clk);
    fault <= f;
  endtask

  // zero-cross sense: every call is one edge, rising or falling
  task automatic cap_edge();
    @(posedge ref_clk);
    capture_in <= ~capture_in;
  endtask
endmodule

// File: arpt_pkg.sv
/*
  arpt_pkg: register indices, field positions, reset values and clock
  selection codes for the autoreload PWM timer with shutdown input.
  Assumes a 32-bit APB slave in which each byte register takes one word.
*/
package arpt_pkg;
  localparam int unsigned CNT_W   = 12;
  localparam int unsigned NUM_CH  = 4;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_CSR    = 6'h0d;
  localparam logic [5:0] IDX_CNTH   = 6'h0e;
  localparam logic [5:0] IDX_CNTL   = 6'h0f;
  localparam logic [5:0] IDX_RLDH   = 6'h10;
  localparam logic [5:0] IDX_RLDL   = 6'h11;
  localparam logic [5:0] IDX_OEN    = 6'h12;
  localparam logic [5:0] IDX_CCS0   = 6'h13;
  localparam logic [5:0] IDX_DUTY0H = 6'h17;
  localparam logic [5:0] IDX_CAPH   = 6'h1f;
  localparam logic [5:0] IDX_CAPL   = 6'h20;
  localparam logic [5:0] IDX_XFER   = 6'h21;
  localparam logic [5:0] IDX_BRK    = 6'h22;

  // timer control/status fields
  localparam int unsigned CSR_ICF    = 6;
  localparam int unsigned CSR_CAPTURE_IRQ_EN   = 5;
  localparam int unsigned CSR_SEL    = 3;
  localparam int unsigned CSR_OVF    = 2;
  localparam int unsigned CSR_OVERFLOW_IRQ_EN  = 1;
  localparam int unsigned CSR_COMPARE_IRQ_EN  = 0;
  // channel control/status fields
  localparam int unsigned CCS_POL    = 1;
  localparam int unsigned CCS_MATCH_FLAG   = 0;
  // shutdown control fields
  localparam int unsigned BRK_BA     = 5;
  localparam int unsigned BRK_PEN    = 4;
  // transfer control field
  localparam int unsigned XFER_BIT   = 0;

  // counter clock selection
  localparam logic [1:0] SEL_OFF  = 2'h0;
  localparam logic [1:0] SEL_LITE = 2'h1;
  localparam logic [1:0] SEL_CPU  = 2'h2;
  localparam logic [1:0] SEL_FAST = 2'h3;

  localparam logic [11:0] CNT_MAX    = 12'hfff;
  localparam logic [11:0] CNT_RST    = 12'h000;
  localparam logic        XFER_RST   = 1'b1;
  localparam logic        SHDN_IDLE  = 1'b1;
  // slow mode divides the counter clock by 32
  localparam int unsigned SLOW_DIV   = 32;
  localparam logic [4:0]  PRESC_LAST = 5'(SLOW_DIV - 1);
endpackage

// File: arpt_sync2.sv
/*
  arpt_sync2: two-stage synchroniser for one level.
  Assumes the input may change at any time relative to ref_clk.
*/
`timescale 1ns/1ps
module arpt_sync2 #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic async_in,
  output logic      sync_out
);
  typedef struct packed {
    logic ff1;
    logic ff2;
  } arpt_sync_t;

  arpt_sync_t st;
  arpt_sync_t next_st;

  // first stage is read only by the second stage
  always_comb begin
    next_st     = st;
    next_st.ff1 = async_in;
    next_st.ff2 = st.ff1;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st <= {RST_VAL, RST_VAL};
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.ff2;
endmodule

// File: arpt_timer.sv
/*
  arpt_timer: 12-bit autoreload timer with four PWM/compare channels,
  shutdown input, one input capture, APB register access.
  Assumes inputs synchronous to ref_clk except shutdown_in; lite and fast
  clock sources arrive as one-cycle tick pulses on ref_clk.
*/
`timescale 1ns/1ps
// Overview of operation
// - nonzero duty match with counter sets compare flag and requests interrupt
// - a channel with zero duty never performs output compare
// - enabled shutdown pin sampled low sets shutdown_active, entering break
// - software writing one to shutdown_active enters break like the pin
// - during break, outputs show the break pattern, bypassing polarity inversion
// - break entry resets counter, reload, duties, active duties and output enables; polarity shadow kept
// - clearing shutdown_active returns the pins to general-purpose port logic
// - capture_in edge latches counter, sets capture flag, requests interrupt
// - reading either capture byte clears capture flag; writes leave it
// - further capture edges ignored while capture flag is set
// - slow divides clock by 32; halt stops; active-halt stops unless lite+irq
// - compare and capture share one request; overflow separate; wake rules
// - clock select codes off, lite, cpu, fast; change applies at overflow, or at once while off
// - overflow sets overflow flag, requests interrupt; status read clears
// - counter runs with a clock selected and reloads on overflow
// - output enable bit gives the pin to PWM; clear leaves it to GPIO
// - polarity bit inverts the channel output; resets to zero
// - reading channel status clears its compare flag; hardware sets it
// - channel status upper bits kept clear; shutdown top bits read zero
// - overflow loads preloaded duties and drives outputs high; match drives low
// - transfer enable resets set; overflow copies duty and polarity, then clears
module arpt_timer
  import arpt_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              lite_tick,
  input  wire logic              fast_tick,
  input  wire logic              slow_mode,
  input  wire logic              wait_mode,
  input  wire logic              halt_mode,
  input  wire logic              active_halt_mode,
  input  wire logic              shutdown_in_n,
  input  wire logic              capture_in,
  output logic [3:0]             modulated_out,
  output logic [3:0]             modulated_oe_n,
  output logic                   irq_cmp_cap,
  output logic                   irq_ovf,
  output logic                   wake_req
);
  typedef struct packed {
    logic [11:0]      cnt;
    logic [11:0]      reload;
    logic [11:0]      capv;
    logic [3:0][11:0] duty;
    logic [3:0][11:0] duty_act;
    logic [3:0]       pol;
    logic [3:0]       pol_sh;
    logic [3:0]       oe;
    logic [3:0]       match_flag;
    logic [3:0]       pattern;
    logic [3:0]       raw;
    logic [3:0]       pwm;
    logic [3:0]       pwm_oe_n;
    logic [3:0]       hi_buf;
    logic [1:0]       sel;
    logic [1:0]       act_sel;
    logic [4:0]       presc;
    logic             ovf;
    logic             capture_flag;
    logic             capture_irq_en;
    logic             overflow_irq_en;
    logic             compare_irq_en;
    logic             xfer;
    logic             ba;
    logic             shutdown_pin_en;
    logic             cap_prev;
    logic             cap_ok;
    logic             irq_ovf;
    logic             irq_cc;
    logic             wake;
    logic             pready;
    logic             pslverr;
    logic [7:0]       prdata;
  } arpt_state_t;

  arpt_state_t st;
  arpt_state_t next_st;

  logic       shdn_sync;
  logic [6:0] dec;
  logic [5:0] idx;
  logic       hit;
  logic       setup_acc;
  logic       wr;
  logic       rd;
  logic [7:0] rbyte;
  logic       src_tick;
  logic       halted;
  logic       tick;
  logic       ovf_evt;
  logic [3:0] match;
  logic       cap_edge;
  logic       icf_clr;
  logic       entry;

  function automatic logic [6:0] arpt_decode(input logic [ADDR_W-1:0] a);
    logic [5:0] i;
    i = a[7:2];
    // shift keeps the upper-bit test legal when the bus is exactly eight bits wide
    return {(a[1:0] == 2'b00) && ((a >> 8) == '0) && (i >= IDX_CSR) && (i <= IDX_BRK), i};
  endfunction

  arpt_sync2 #(
    .RST_VAL (SHDN_IDLE)
  ) u_shdn_sync (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .async_in (shutdown_in_n),
    .sync_out (shdn_sync)
  );

  always_comb begin
    next_st   = st;
    dec       = arpt_decode(paddr);
    hit       = dec[6];
    idx       = dec[5:0];
    setup_acc = psel & penable & ~st.pready;
    wr        = psel & penable & st.pready & pwrite & hit;
    rd        = psel & penable & st.pready & ~pwrite & hit;

    // read mux; unmapped and reserved bits read as zero
    rbyte = 8'h00;
    case (idx)
      IDX_CSR:  rbyte = {1'b0, st.capture_flag, st.capture_irq_en, st.sel, st.ovf, st.overflow_irq_en, st.compare_irq_en};
      IDX_CNTH: rbyte = {4'h0, st.hi_buf};
      IDX_CNTL: rbyte = st.cnt[7:0];
      IDX_RLDH: rbyte = {4'h0, st.reload[11:8]};
      IDX_RLDL: rbyte = st.reload[7:0];
      IDX_OEN:  rbyte = {1'b0, st.oe[3], 1'b0, st.oe[2], 1'b0, st.oe[1], 1'b0, st.oe[0]};
      IDX_CAPH: rbyte = {4'h0, st.capv[11:8]};
      IDX_CAPL: rbyte = st.capv[7:0];
      IDX_XFER: rbyte = {7'h00, st.xfer};
      IDX_BRK:  rbyte = {2'b00, st.ba, st.shutdown_pin_en, st.pattern};
      default: begin
        for (int c = 0; c < NUM_CH; c++) begin
          if (idx == IDX_CCS0 + 6'(c)) begin
            rbyte = {6'h00, st.pol[c], st.match_flag[c]};
          end
          if (idx == IDX_DUTY0H + 6'(2 * c)) begin
            rbyte = {4'h0, st.duty[c][11:8]};
          end
          if (idx == IDX_DUTY0H + 6'(2 * c + 1)) begin
            rbyte = st.duty[c][7:0];
          end
        end
      end
    endcase

    // one wait state: data is sampled in the first access cycle
    next_st.pready  = setup_acc;
    next_st.pslverr = setup_acc & ~hit;
    if (setup_acc) begin
      next_st.prdata = hit ? rbyte : 8'h00;
    end
    // high byte frozen with the low byte so a split read stays coherent
    if (setup_acc && hit && !pwrite && idx == IDX_CNTL) begin
      next_st.hi_buf = st.cnt[11:8];
    end

    // counter clock source and low-power gating
    case (st.act_sel)
      SEL_OFF:  src_tick = 1'b0;
      SEL_LITE: src_tick = lite_tick;
      SEL_CPU:  src_tick = 1'b1;
      SEL_FAST: src_tick = fast_tick;
      default:  src_tick = 1'b0;
    endcase
    halted = halt_mode
           | (active_halt_mode & ~(st.act_sel == SEL_LITE & st.overflow_irq_en));
    tick   = src_tick & ~halted & (~slow_mode | (st.presc == PRESC_LAST));
    if (src_tick && !halted && slow_mode) begin
      next_st.presc = st.presc + 5'h01;
    end
    ovf_evt = tick & (st.cnt == CNT_MAX);

    if (tick) begin
      next_st.cnt = ovf_evt ? st.reload : st.cnt + 12'h001;
    end
    // a stopped counter never overflows, so it takes a new source at once
    if (ovf_evt || st.act_sel == SEL_OFF) begin
      next_st.act_sel = st.sel;
    end
    if (ovf_evt && st.xfer) begin
      next_st.duty_act = st.duty;
      next_st.pol_sh   = st.pol;
      next_st.xfer     = 1'b0;
    end

    for (int c = 0; c < NUM_CH; c++) begin
      match[c] = tick & (st.duty_act[c] != CNT_RST) & (st.cnt == st.duty_act[c]);
      if (ovf_evt) begin
        next_st.raw[c] = 1'b1;
      end else if (match[c]) begin
        next_st.raw[c] = 1'b0;
      end
      if (rd && idx == IDX_CCS0 + 6'(c) && st.prdata[CCS_MATCH_FLAG]) begin
        next_st.match_flag[c] = 1'b0;
      end
      if (match[c]) begin
        next_st.match_flag[c] = 1'b1;
      end
    end

    // register writes; status flags are not writable
    if (wr) begin
      case (idx)
        IDX_CSR: begin
          next_st.capture_irq_en  = pwdata[CSR_CAPTURE_IRQ_EN];
          next_st.sel   = pwdata[CSR_SEL+1:CSR_SEL];
          next_st.overflow_irq_en = pwdata[CSR_OVERFLOW_IRQ_EN];
          next_st.compare_irq_en = pwdata[CSR_COMPARE_IRQ_EN];
        end
        IDX_RLDH: next_st.reload[11:8] = pwdata[3:0];
        IDX_RLDL: next_st.reload[7:0]  = pwdata[7:0];
        IDX_OEN: begin
          for (int c = 0; c < NUM_CH; c++) begin
            next_st.oe[c] = pwdata[2 * c];
          end
        end
        IDX_XFER: next_st.xfer = pwdata[XFER_BIT];
        IDX_BRK: begin
          next_st.ba      = pwdata[BRK_BA];
          next_st.shutdown_pin_en    = pwdata[BRK_PEN];
          next_st.pattern = pwdata[3:0];
        end
        default: begin
          for (int c = 0; c < NUM_CH; c++) begin
            if (idx == IDX_CCS0 + 6'(c)) begin
              next_st.pol[c] = pwdata[CCS_POL];
            end
            if (idx == IDX_DUTY0H + 6'(2 * c)) begin
              next_st.duty[c][11:8] = pwdata[3:0];
            end
            if (idx == IDX_DUTY0H + 6'(2 * c + 1)) begin
              next_st.duty[c][7:0] = pwdata[7:0];
            end
          end
        end
      endcase
    end

    // overflow flag: cleared only if the read really showed it, set wins
    if (rd && idx == IDX_CSR && st.prdata[CSR_OVF]) begin
      next_st.ovf = 1'b0;
    end
    if (ovf_evt) begin
      next_st.ovf = 1'b1;
    end

    // input capture
    cap_edge         = st.cap_ok & (capture_in != st.cap_prev);
    next_st.cap_prev = capture_in;
    next_st.cap_ok   = 1'b1;
    icf_clr          = rd & (idx == IDX_CAPH || idx == IDX_CAPL) & st.capture_flag;
    if (icf_clr) begin
      next_st.capture_flag = 1'b0;
    end
    if (cap_edge && !st.capture_flag) begin
      next_st.capv = st.cnt;
      next_st.capture_flag  = 1'b1;
    end

    // shutdown pin only counts once software has enabled it
    if (st.shutdown_pin_en && !shdn_sync) begin
      next_st.ba = 1'b1;
    end
    entry = next_st.ba & ~st.ba;
    if (entry) begin
      next_st.cnt      = CNT_RST;
      next_st.reload   = CNT_RST;
      next_st.duty     = '0;
      next_st.duty_act = '0;
      next_st.oe       = 4'h0;
    end

    // pins: break pattern bypasses the polarity inverter
    for (int c = 0; c < NUM_CH; c++) begin
      next_st.pwm[c]      = next_st.ba ? next_st.pattern[c]
                                       : next_st.raw[c] ^ next_st.pol_sh[c];
      next_st.pwm_oe_n[c] = next_st.ba ? 1'b0 : ~next_st.oe[c];
    end

    next_st.irq_ovf = next_st.ovf & next_st.overflow_irq_en;
    next_st.irq_cc  = (next_st.capture_flag & next_st.capture_irq_en)
                    | ((|next_st.match_flag) & next_st.compare_irq_en);
    next_st.wake    = (wait_mode & (next_st.irq_ovf | next_st.irq_cc))
                    | (active_halt_mode & ~halt_mode & next_st.irq_ovf
                       & (next_st.act_sel == SEL_LITE));
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st          <= '0;
      st.xfer     <= XFER_RST;
      st.pwm_oe_n <= 4'hf;
    end else begin
      st <= next_st;
    end
  end

  assign prdata         = {24'h00_0000, st.prdata};
  assign pready         = st.pready;
  assign pslverr        = st.pslverr;
  assign modulated_out  = st.pwm;
  assign modulated_oe_n = st.pwm_oe_n;
  assign irq_cmp_cap    = st.irq_cc;
  assign irq_ovf        = st.irq_ovf;
  assign wake_req       = st.wake;

  property p_cmp_set;
    @(posedge ref_clk) disable iff (!rst_n) match[0] |=> st.match_flag[0];
  endproperty
  a_cmp_set: assert property (p_cmp_set) else $error("compare flag not set on match");

  property p_zero_duty;
    @(posedge ref_clk) disable iff (!rst_n)
      (st.duty_act[0] == 12'h000) && !st.match_flag[0] |=> !st.match_flag[0];
  endproperty
  a_zero_duty: assert property (p_zero_duty) else $error("compare on zero duty");

  property p_pin_break;
    @(posedge ref_clk) disable iff (!rst_n) st.shutdown_pin_en && !shdn_sync |=> st.ba;
  endproperty
  a_pin_break: assert property (p_pin_break) else $error("pin did not enter break");

  property p_pattern;
    @(posedge ref_clk) disable iff (!rst_n)
      st.ba |-> (modulated_out == st.pattern) && (modulated_oe_n == 4'h0);
  endproperty
  a_pattern: assert property (p_pattern) else $error("break pattern not on pins");

  property p_entry;
    @(posedge ref_clk) disable iff (!rst_n)
      !st.ba ##1 st.ba |-> (st.cnt == 12'h000) && (st.reload == 12'h000)
                           && (st.oe == 4'h0) && (st.duty == '0);
  endproperty
  a_entry: assert property (p_entry) else $error("break entry did not reset");

  property p_capture;
    @(posedge ref_clk) disable iff (!rst_n)
      cap_edge && !st.capture_flag |=> st.capture_flag && (st.capv == $past(st.cnt));
  endproperty
  a_capture: assert property (p_capture) else $error("capture not latched");

  property p_cap_hold;
    @(posedge ref_clk) disable iff (!rst_n) st.capture_flag && !icf_clr |=> $stable(st.capv);
  endproperty
  a_cap_hold: assert property (p_cap_hold) else $error("capture overwritten");

  property p_ovf_reload;
    @(posedge ref_clk) disable iff (!rst_n)
      ovf_evt && !entry |=> st.ovf && (st.cnt == $past(st.reload));
  endproperty
  a_ovf_reload: assert property (p_ovf_reload) else $error("overflow reload wrong");

  property p_ovf_clear;
    @(posedge ref_clk) disable iff (!rst_n)
      rd && (idx == IDX_CSR) && st.prdata[CSR_OVF] && !ovf_evt |=> !st.ovf;
  endproperty
  a_ovf_clear: assert property (p_ovf_clear) else $error("status read kept flag");

  property p_apb_ready;
    @(posedge ref_clk) disable iff (!rst_n)
      psel && penable && !pready |=> pready ##1 !pready;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("apb ready timing wrong");
endmodule

// File: arpt_timer_bench.sv
/*
  arpt_timer_bench: self-checking bench for arpt_timer over APB.
  Assumes one wait state per access and a converter model on the pins.
*/
`timescale 1ns/1ps
module arpt_timer_bench;
  import arpt_pkg::*;
  logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, d, lo, hi;
  logic        slow_mode, wait_mode, halt_mode, active_halt_mode, lite_tick, fast_tick;
  logic        shutdown_in_n, capture_in, irq_cmp_cap, irq_ovf, wake_req, e;
  logic [3:0]  modulated_out, modulated_oe_n;
  logic [11:0] cap_a, cap_c;
  int          err_count, n_tests, cyc, t_a;

  arpt_timer u_arpt_timer (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lite_tick(lite_tick), .fast_tick(fast_tick), .slow_mode(slow_mode),
    .wait_mode(wait_mode), .halt_mode(halt_mode), .active_halt_mode(active_halt_mode),
    .shutdown_in_n(shutdown_in_n), .capture_in(capture_in), .modulated_out(modulated_out),
    .modulated_oe_n(modulated_oe_n), .irq_cmp_cap(irq_cmp_cap), .irq_ovf(irq_ovf),
    .wake_req(wake_req));
  arpt_conv_stage u_arpt_conv_stage (.ref_clk(ref_clk), .modulated_out(modulated_out),
    .modulated_oe_n(modulated_oe_n), .shutdown_in_n(shutdown_in_n), .capture_in(capture_in));

  initial begin
    ref_clk = 1'b0; rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0000_0000; slow_mode = 1'b0; wait_mode = 1'b0;
    halt_mode = 1'b0; active_halt_mode = 1'b0; lite_tick = 1'b0; fast_tick = 1'b0;
    err_count = 0; n_tests = 0; cyc = 0;
  end
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  // request held until pready is sampled high at a rising edge
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge ref_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= {idx, 2'b00}; pwdata <= {24'h0, wd};
    @(posedge ref_clk);
    penable <= 1'b1;
    // no local limit: a slave that never answers is caught by the watchdog
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
    logic [31:0] r;
    logic        x;
    apb(1'b1, idx, wd, r, x);
  endtask

  task automatic rdchk(input string name, input logic [5:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00, d, e);
    chk(name, exp, d);
  endtask

  // bounded wait: a counter period is 4096 cycles with reload zero
  task automatic wait_ovf();
    int n;
    n = 0;
    while (irq_ovf !== 1'b1 && n < 5000) begin
      @(posedge ref_clk);
      n++;
    end
    chk("ovf_wait", 32'h1, {31'h0, irq_ovf});
  endtask

  task automatic t_reset_regs();
    rdchk("csr", IDX_CSR, 32'h0000_0000);
    rdchk("xfer", IDX_XFER, 32'h0000_0001);
    rdchk("brk", IDX_BRK, 32'h0000_0000);
    rdchk("ccs0", IDX_CCS0, 32'h0000_0000);
    chk("oe_rst", 32'hf, {28'h0, modulated_oe_n});
    apb(1'b0, 6'h01, 8'h00, d, e);
    chk("unmapped_err", 32'h1, {31'h0, e});
    chk("unmapped_data", 32'h0, d);
    $display("done reset_regs");
  endtask

  task automatic t_pwm();
    wr(IDX_DUTY0H + 6'h01, 8'h10);
    wr(IDX_OEN, 8'h01);
    // cpu clock, no lite source while pwm runs; icf write must not stick
    wr(IDX_CSR, 8'h53);
    wait_ovf();
    chk("pwm_hi", 32'h1, {31'h0, modulated_out[0]});
    chk("oe_on", 32'he, {28'h0, modulated_oe_n});
    wait_mode <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk("wake", 32'h1, {31'h0, wake_req});
    wait_mode <= 1'b0;
    repeat (20) @(posedge ref_clk);
    chk("pwm_lo", 32'h0, {31'h0, modulated_out[0]});
    chk("irq_cmp", 32'h1, {31'h0, irq_cmp_cap});
    rdchk("match_flag_set", IDX_CCS0, 32'h0000_0001);
    rdchk("match_flag_clr", IDX_CCS0, 32'h0000_0000);
    rdchk("match_flag_zero", IDX_CCS0 + 6'h01, 32'h0000_0000);
    rdchk("ovf_set", IDX_CSR, 32'h0000_0017);
    rdchk("ovf_clr", IDX_CSR, 32'h0000_0013);
    rdchk("xfer_done", IDX_XFER, 32'h0000_0000);
    $display("done pwm");
  endtask

  task automatic t_halt();
    halt_mode <= 1'b1;
    apb(1'b0, IDX_CNTL, 8'h00, lo, e);
    apb(1'b0, IDX_CNTH, 8'h00, hi, e);
    // counter restarted from zero a few dozen cycles ago
    chk("cnt_hi", 32'h0, hi);
    rdchk("cnt_frozen", IDX_CNTL, lo);
    halt_mode <= 1'b0;
    active_halt_mode <= 1'b1;
    apb(1'b0, IDX_CNTL, 8'h00, lo, e);
    rdchk("ahalt_frozen", IDX_CNTL, lo);
    active_halt_mode <= 1'b0;
    // sample points 320 cycles apart: exactly ten divided ticks
    slow_mode <= 1'b1;
    apb(1'b0, IDX_CNTL, 8'h00, lo, e);
    repeat (316) @(posedge ref_clk);
    apb(1'b0, IDX_CNTL, 8'h00, hi, e);
    chk("slow_div", 32'd10, {24'h0, hi[7:0] - lo[7:0]});
    slow_mode <= 1'b0;
    // lite source chosen but no overflow yet: cpu rate must persist
    wr(IDX_CSR, 8'h0b);
    apb(1'b0, IDX_CNTL, 8'h00, lo, e);
    apb(1'b0, IDX_CNTL, 8'h00, hi, e);
    chk("sel_defer", 32'd4, {24'h0, hi[7:0] - lo[7:0]});
    wr(IDX_CSR, 8'h13);
    $display("done halt");
  endtask

  task automatic t_polarity();
    wr(IDX_CCS0, 8'h02);
    wr(IDX_XFER, 8'h01);
    wait_ovf();
    chk("inv_hi", 32'h0, {31'h0, modulated_out[0]});
    repeat (20) @(posedge ref_clk);
    chk("inv_lo", 32'h1, {31'h0, modulated_out[0]});
    $display("done polarity");
  endtask

  task automatic t_capture();
    u_arpt_conv_stage.cap_edge();
    t_a = cyc;
    repeat (40) @(posedge ref_clk);
    // second edge arrives while the flag is up
    u_arpt_conv_stage.cap_edge();
    repeat (5) @(posedge ref_clk);
    apb(1'b0, IDX_CSR, 8'h00, d, e);
    chk("icf_set", 32'h1, {31'h0, d[6]});
    apb(1'b0, IDX_CAPL, 8'h00, lo, e);
    apb(1'b0, IDX_CAPH, 8'h00, hi, e);
    cap_a = {hi[3:0], lo[7:0]};
    apb(1'b0, IDX_CSR, 8'h00, d, e);
    chk("icf_clr", 32'h0, {31'h0, d[6]});
    while (cyc < t_a + 299) @(posedge ref_clk);
    u_arpt_conv_stage.cap_edge();
    repeat (5) @(posedge ref_clk);
    apb(1'b0, IDX_CAPL, 8'h00, lo, e);
    apb(1'b0, IDX_CAPH, 8'h00, hi, e);
    cap_c = {hi[3:0], lo[7:0]};
    // reload zero gives a 4096 period, so the gap is exact modulo 12 bits
    chk("cap_gap", 32'h0000_012c, {20'h0, cap_c - cap_a});
    $display("done capture");
  endtask

  task automatic t_sw_break();
    wr(IDX_RLDL, 8'h55);
    wr(IDX_BRK, 8'hea);
    repeat (2) @(posedge ref_clk);
    chk("pat_out", 32'ha, {28'h0, modulated_out});
    chk("gate_on", 32'ha, {28'h0, u_arpt_conv_stage.gate_on});
    chk("pat_oe", 32'h0, {28'h0, modulated_oe_n});
    rdchk("brk_top", IDX_BRK, 32'h0000_002a);
    rdchk("oen_rst", IDX_OEN, 32'h0000_0000);
    rdchk("rld_rst", IDX_RLDL, 32'h0000_0000);
    rdchk("duty_rst", IDX_DUTY0H + 6'h01, 32'h0000_0000);
    wr(IDX_BRK, 8'h0a);
    repeat (2) @(posedge ref_clk);
    chk("gpio_back", 32'hf, {28'h0, modulated_oe_n});
    $display("done sw_break");
  endtask

  task automatic t_pin_break();
    u_arpt_conv_stage.set_fault(1'b1);
    repeat (6) @(posedge ref_clk);
    rdchk("pin_off", IDX_BRK, 32'h0000_000a);
    wr(IDX_BRK, 8'h1a);
    repeat (4) @(posedge ref_clk);
    chk("pin_pat", 32'ha, {28'h0, modulated_out});
    rdchk("pin_ba", IDX_BRK, 32'h0000_003a);
    u_arpt_conv_stage.set_fault(1'b0);
    repeat (4) @(posedge ref_clk);
    wr(IDX_BRK, 8'h00);
    repeat (2) @(posedge ref_clk);
    chk("pin_gpio", 32'hf, {28'h0, modulated_oe_n});
    $display("done pin_break");
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // whole run is near 9000 cycles; the limit leaves ample margin
  initial begin
    repeat (40000) @(posedge ref_clk);
    err_count++;
    give_verdict();
  end

  initial begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset_regs();
    t_pwm();
    t_halt();
    t_polarity();
    t_capture();
    t_sw_break();
    t_pin_break();
    give_verdict();
  end
endmodule
